/* include/fault_map.vh */
// How it works
// - guard clear bit zeroes both guard flag registers
// - under-temp clear bit zeroes under-temp flags
// - over-temp clear bit zeroes over-temp flags
// - cell voltage clear bits zero their flags
// - adc cross-check clear bit zeroes its flags
// - core-health clear zeroes flags, bit self-clears
// - supply-rail clear zeroes three registers, self-clears
// - rollup register mirrors fault alert conditions
// - rollup guard bit: unmasked and any set
// - rollup guard bit zero without comparator faults
// - rollup temp bit: each source own mask
// - rollup voltage bit: each source own mask
// - rollup adc bit: unmasked and any set
// - rollup supply bit: unmasked and any set
`ifndef FAULT_MAP_VH
`define FAULT_MAP_VH

`define ADDR_W 16
`define DATA_W 8
`define GROUPS 16
`define FLAGS_W 128

`define ADDR_CLEAR_A 16'h0331
`define ADDR_CLEAR_B 16'h0332
`define ADDR_ROLLUP 16'h052d
`define ADDR_FLAGS_BASE 16'h0600
`define ADDR_IRQ_STATUS 16'h0700
`define ADDR_IRQ_ENABLE 16'h0701
`define ADDR_IRQ_CLEAR 16'h0702
`define REG_RESET 8'h00

// clear register a bits
`define CA_GUARD 7
`define CA_UNDER_TEMP 6
`define CA_OVER_TEMP 5
`define CA_LOW_CELL 4
`define CA_HIGH_CELL 3
`define CA_ADC 2
`define CA_CORE 1
`define CA_SUPPLY 0

// clear register b bits
`define CB_FUSE_CRC 6
`define CB_FUSE_DATA 5
`define CB_LINK_FRAME 4
`define CB_LINK_TONE 3
`define CB_LINK_HB 2
`define CB_CHAIN 1
`define CB_HOST 0

// flag register group indices
`define G_GUARD_A 4'h0
`define G_GUARD_B 4'h1
`define G_UNDER_TEMP 4'h2
`define G_OVER_TEMP 4'h3
`define G_LOW_CELL 4'h4
`define G_HIGH_CELL 4'h5
`define G_ADC 4'h6
`define G_CORE 4'h7
`define G_SUPPLY_A 4'h8
`define G_SUPPLY_B 4'h9
`define G_SUPPLY_C 4'ha
`define G_FUSE_CRC 4'hb
`define G_FUSE_DATA 4'hc
`define G_LINK 4'hd
`define G_CHAIN 4'he
`define G_HOST 4'hf

// link fault register bits
`define LK_HB_FAST 0
`define LK_HB_FAIL 1
`define LK_TONE 2
`define LK_FRAME 3

// mask input bits
`define M_SUPPLY 0
`define M_CORE 1
`define M_ADC 2
`define M_HIGH_CELL 3
`define M_LOW_CELL 4
`define M_OVER_TEMP 5
`define M_UNDER_TEMP 6
`define M_GUARD 7
`define M_HOST 8
`define M_CHAIN 9
`define M_LINK_HB 10
`define M_LINK_TONE 11
`define M_LINK_FRAME 12
`define M_FUSE_DATA 13
`define M_FUSE_CRC 14
`define MASK_W 15

// rollup bits
`define RU_GUARD 7
`define RU_ADC 6
`define RU_FUSE 5
`define RU_LINK 4
`define RU_TEMP 3
`define RU_VOLT 2
`define RU_CORE 1
`define RU_SUPPLY 0

`endif

/* src/fault_flag_bank.v */
`timescale 1ns/1ps
`include "fault_map.vh"

module fault_flag_bank (
	input wire sys_clk,
	input wire rst,
	input wire [7:0] set_bits,
	input wire [7:0] clear_bits,
	output reg [7:0] flags_reg
);
	wire [7:0] flags_next;

	// set wins over a clear in the same cycle
	assign flags_next = (flags_reg & ~clear_bits) | set_bits;

	always @(posedge sys_clk) begin
		if (rst) begin
			flags_reg <= `REG_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end
endmodule

/* src/fault_clear_and_rollup.v */
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "fault_map.vh"

module fault_clear_and_rollup (
	input wire sys_clk,
	input wire rst,
	input wire [`ADDR_W-1:0] addr,
	input wire [`DATA_W-1:0] wr_data,
	input wire wr_en,
	input wire rd_en,
	input wire [`FLAGS_W-1:0] fault_set,
	input wire [`MASK_W-1:0] fault_mask,
	output reg [`DATA_W-1:0] rd_data_reg,
	output reg [`DATA_W-1:0] fault_rollup_reg,
	output reg fault_alert_pin_n_reg,
	output reg irq_reg
);
	reg [7:0] clear_a_reg;
	reg [7:0] clear_b_reg;
	reg [7:0] irq_status_reg;
	reg [7:0] irq_enable_reg;
	reg [7:0] rollup_next;
	reg [7:0] rd_next;
	reg [7:0] irq_status_next;
	reg [`FLAGS_W-1:0] clear_vec;
	wire [`FLAGS_W-1:0] flags_all;
	wire [7:0] rollup_rise;
	wire hit_flags;
	wire [3:0] flag_idx;
	genvar g;

	// one flag register of the flat flag vector
	function [7:0] group_flags;
		input [`FLAGS_W-1:0] all;
		input [3:0] idx;
		begin
			group_flags = all[idx*8 +: 8];
		end
	endfunction

	// any bit of a group set while its mask is clear
	function group_alert;
		input [`FLAGS_W-1:0] all;
		input [3:0] idx;
		input masked;
		begin
			group_alert = ~masked & (|all[idx*8 +: 8]);
		end
	endfunction

	assign hit_flags = ((addr & 16'hfff0) == `ADDR_FLAGS_BASE);
	assign flag_idx = addr[3:0];

	always @(posedge sys_clk) begin
		if (rst) begin
			clear_a_reg <= `REG_RESET;
			clear_b_reg <= `REG_RESET;
		end else begin
			if (wr_en && addr == `ADDR_CLEAR_A) begin
				clear_a_reg <= wr_data;
			end else begin
				clear_a_reg <= `REG_RESET;
			end
			if (wr_en && addr == `ADDR_CLEAR_B) begin
				clear_b_reg <= wr_data & 8'h7f;
			end else begin
				clear_b_reg <= `REG_RESET;
			end
		end
	end

	// per-register clear vectors
	always @* begin
		clear_vec = {`FLAGS_W{1'b0}};
		clear_vec[`G_GUARD_A*8 +: 8] = {8{clear_a_reg[`CA_GUARD]}};
		clear_vec[`G_GUARD_B*8 +: 8] = {8{clear_a_reg[`CA_GUARD]}};
		clear_vec[`G_UNDER_TEMP*8 +: 8] = {8{clear_a_reg[`CA_UNDER_TEMP]}};
		clear_vec[`G_OVER_TEMP*8 +: 8] = {8{clear_a_reg[`CA_OVER_TEMP]}};
		clear_vec[`G_LOW_CELL*8 +: 8] = {8{clear_a_reg[`CA_LOW_CELL]}};
		clear_vec[`G_HIGH_CELL*8 +: 8] = {8{clear_a_reg[`CA_HIGH_CELL]}};
		clear_vec[`G_ADC*8 +: 8] = {8{clear_a_reg[`CA_ADC]}};
		clear_vec[`G_CORE*8 +: 8] = {8{clear_a_reg[`CA_CORE]}};
		clear_vec[`G_SUPPLY_A*8 +: 8] = {8{clear_a_reg[`CA_SUPPLY]}};
		clear_vec[`G_SUPPLY_B*8 +: 8] = {8{clear_a_reg[`CA_SUPPLY]}};
		clear_vec[`G_SUPPLY_C*8 +: 8] = {8{clear_a_reg[`CA_SUPPLY]}};
		clear_vec[`G_FUSE_CRC*8 +: 8] = {8{clear_b_reg[`CB_FUSE_CRC]}};
		clear_vec[`G_FUSE_DATA*8 +: 8] = {8{clear_b_reg[`CB_FUSE_DATA]}};
		clear_vec[`G_LINK*8 + `LK_FRAME] = clear_b_reg[`CB_LINK_FRAME];
		clear_vec[`G_LINK*8 + `LK_TONE] = clear_b_reg[`CB_LINK_TONE];
		clear_vec[`G_LINK*8 + `LK_HB_FAST] = clear_b_reg[`CB_LINK_HB];
		clear_vec[`G_LINK*8 + `LK_HB_FAIL] = clear_b_reg[`CB_LINK_HB];
		clear_vec[`G_CHAIN*8 +: 8] = {8{clear_b_reg[`CB_CHAIN]}};
		clear_vec[`G_HOST*8 +: 8] = {8{clear_b_reg[`CB_HOST]}};
	end

	generate
		for (g = 0; g < `GROUPS; g = g + 1) begin : bank
			fault_flag_bank u_bank (
				.sys_clk(sys_clk),
				.rst(rst),
				.set_bits(fault_set[g*8 +: 8]),
				.clear_bits(clear_vec[g*8 +: 8]),
				.flags_reg(flags_all[g*8 +: 8])
			);
		end
	endgenerate

	always @* begin
		rollup_next = 8'h00;
		rollup_next[`RU_GUARD] = ~fault_mask[`M_GUARD] &
			(|(group_flags(flags_all, `G_GUARD_A) |
			group_flags(flags_all, `G_GUARD_B)));
		rollup_next[`RU_ADC] = group_alert(flags_all, `G_ADC,
			fault_mask[`M_ADC]);
		rollup_next[`RU_FUSE] =
			group_alert(flags_all, `G_FUSE_CRC, fault_mask[`M_FUSE_CRC]) |
			group_alert(flags_all, `G_FUSE_DATA, fault_mask[`M_FUSE_DATA]);
		rollup_next[`RU_LINK] =
			group_alert(flags_all, `G_HOST, fault_mask[`M_HOST]) |
			group_alert(flags_all, `G_CHAIN, fault_mask[`M_CHAIN]) |
			(~fault_mask[`M_LINK_HB] &
			(flags_all[`G_LINK*8 + `LK_HB_FAST] |
			flags_all[`G_LINK*8 + `LK_HB_FAIL])) |
			(~fault_mask[`M_LINK_TONE] & flags_all[`G_LINK*8 + `LK_TONE]) |
			(~fault_mask[`M_LINK_FRAME] & flags_all[`G_LINK*8 + `LK_FRAME]);
		rollup_next[`RU_TEMP] =
			group_alert(flags_all, `G_OVER_TEMP, fault_mask[`M_OVER_TEMP]) |
			group_alert(flags_all, `G_UNDER_TEMP,
			fault_mask[`M_UNDER_TEMP]);
		rollup_next[`RU_VOLT] =
			group_alert(flags_all, `G_HIGH_CELL, fault_mask[`M_HIGH_CELL]) |
			group_alert(flags_all, `G_LOW_CELL, fault_mask[`M_LOW_CELL]);
		rollup_next[`RU_CORE] = group_alert(flags_all, `G_CORE,
			fault_mask[`M_CORE]);
		rollup_next[`RU_SUPPLY] = ~fault_mask[`M_SUPPLY] &
			(|(group_flags(flags_all, `G_SUPPLY_A) |
			group_flags(flags_all, `G_SUPPLY_B) |
			group_flags(flags_all, `G_SUPPLY_C)));
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			fault_rollup_reg <= `REG_RESET;
			fault_alert_pin_n_reg <= 1'b1;
		end else begin
			fault_rollup_reg <= rollup_next;
			fault_alert_pin_n_reg <= ~(|rollup_next);
		end
	end

	// interrupt: rising rollup bits are the events
	assign rollup_rise = rollup_next & ~fault_rollup_reg;

	always @* begin
		irq_status_next = irq_status_reg;
		if (wr_en && addr == `ADDR_IRQ_CLEAR) begin
			irq_status_next = irq_status_next & ~wr_data;
		end
		irq_status_next = irq_status_next | rollup_rise;
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			irq_status_reg <= `REG_RESET;
			irq_enable_reg <= `REG_RESET;
			irq_reg <= 1'b0;
		end else begin
			irq_status_reg <= irq_status_next;
			if (wr_en && addr == `ADDR_IRQ_ENABLE) begin
				irq_enable_reg <= wr_data;
			end
			irq_reg <= |(irq_status_next & irq_enable_reg);
		end
	end

	// read mux, data in the next cycle
	always @* begin
		rd_next = 8'h00;
		if (hit_flags) begin
			rd_next = group_flags(flags_all, flag_idx);
		end else begin
			case (addr)
			`ADDR_ROLLUP: rd_next = fault_rollup_reg;
			`ADDR_IRQ_STATUS: rd_next = irq_status_reg;
			`ADDR_IRQ_ENABLE: rd_next = irq_enable_reg;
			`ADDR_CLEAR_A: rd_next = 8'h00;
			`ADDR_CLEAR_B: rd_next = 8'h00;
			default: rd_next = 8'h00;
			endcase
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			rd_data_reg <= `REG_RESET;
		end else if (rd_en) begin
			rd_data_reg <= rd_next;
		end else begin
			rd_data_reg <= `REG_RESET;
		end
	end
endmodule

/* sim/fault_rollup_props.sv */
`timescale 1ns/1ps
`include "fault_map.vh"

module fault_rollup_props (
	input wire sys_clk,
	input wire rst,
	input wire [`ADDR_W-1:0] addr,
	input wire [`DATA_W-1:0] wr_data,
	input wire wr_en,
	input wire rd_en,
	input wire [`FLAGS_W-1:0] fault_set,
	input wire [`MASK_W-1:0] fault_mask,
	input wire [`DATA_W-1:0] rd_data_reg,
	input wire [`DATA_W-1:0] fault_rollup_reg,
	input wire fault_alert_pin_n_reg,
	input wire irq_reg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence clear_a_all;
		wr_en && addr == `ADDR_CLEAR_A && wr_data == 8'hff
		##1 fault_set[87:0] == 0;
	endsequence
	sequence clear_b_all;
		wr_en && addr == `ADDR_CLEAR_B && wr_data[6:0] == 7'h7f
		##1 fault_set[127:88] == 0;
	endsequence
	sequence guard_event;
		|fault_set[15:0] && !fault_mask[`M_GUARD] ##1 !fault_mask[`M_GUARD];
	endsequence
	clear_a_a: assert property (
		clear_a_all |=> ##1 !(|(fault_rollup_reg & 8'hcf)))
		else $error("group a clear left a rollup bit set");
	clear_b_a: assert property (
		clear_b_all |=> ##1 !(|(fault_rollup_reg & 8'h30)))
		else $error("group b clear left a rollup bit set");
	guard_set_a: assert property (
		guard_event |=> fault_rollup_reg[`RU_GUARD])
		else $error("guard rollup not raised");
	guard_mask_a: assert property (
		fault_mask[`M_GUARD] |=> !fault_rollup_reg[`RU_GUARD])
		else $error("masked guard rollup raised");
	adc_mask_a: assert property (
		fault_mask[`M_ADC] |=> !fault_rollup_reg[`RU_ADC])
		else $error("masked adc rollup raised");
	supply_mask_a: assert property (
		fault_mask[`M_SUPPLY] |=> !fault_rollup_reg[`RU_SUPPLY])
		else $error("masked supply rollup raised");
	alert_mirror_a: assert property (
		fault_alert_pin_n_reg == !(|fault_rollup_reg))
		else $error("alert disagrees with rollup");
	read_idle_a: assert property (
		!rd_en |=> rd_data_reg == 8'h00)
		else $error("read data outside read slot");
	clear_read_a: assert property (
		rd_en && (addr == `ADDR_CLEAR_A || addr == `ADDR_CLEAR_B)
		|=> rd_data_reg == 8'h00)
		else $error("clear register read not zero");
	rollup_read_a: assert property (
		rd_en && addr == `ADDR_ROLLUP ##1 $stable(fault_rollup_reg)
		|-> rd_data_reg == fault_rollup_reg)
		else $error("rollup read differs");
endmodule

bind fault_clear_and_rollup fault_rollup_props fault_rollup_props_inst (
	.sys_clk(sys_clk),
	.rst(rst),
	.addr(addr),
	.wr_data(wr_data),
	.wr_en(wr_en),
	.rd_en(rd_en),
	.fault_set(fault_set),
	.fault_mask(fault_mask),
	.rd_data_reg(rd_data_reg),
	.fault_rollup_reg(fault_rollup_reg),
	.fault_alert_pin_n_reg(fault_alert_pin_n_reg),
	.irq_reg(irq_reg)
);

/* sim/fault_clear_and_rollup_test.sv */
`timescale 1ns/1ps
`include "fault_map.vh"

module fault_clear_and_rollup_test;
	logic sys_clk = 0;
	logic rst = 1;
	logic wr_en = 0;
	logic rd_en = 0;
	logic [`ADDR_W-1:0] addr = 0;
	logic [`DATA_W-1:0] wr_data = 0;
	logic [`FLAGS_W-1:0] fault_set = 0;
	logic [`MASK_W-1:0] fault_mask = 0;
	wire [`DATA_W-1:0] rd_data_reg;
	wire [`DATA_W-1:0] fault_rollup_reg;
	wire fault_alert_pin_n_reg;
	wire irq_reg;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [35:0] rows [0:15];
	fault_clear_and_rollup fault_clear_and_rollup_inst (
		.sys_clk(sys_clk),
		.rst(rst),
		.addr(addr),
		.wr_data(wr_data),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.fault_set(fault_set),
		.fault_mask(fault_mask),
		.rd_data_reg(rd_data_reg),
		.fault_rollup_reg(fault_rollup_reg),
		.fault_alert_pin_n_reg(fault_alert_pin_n_reg),
		.irq_reg(irq_reg)
	);
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic close_out;
		$display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic look(input logic [7:0] e);
		chk(fault_rollup_reg, e);
		chk({7'h0, fault_alert_pin_n_reg}, {7'h0, e == 8'h00});
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1 chk(rd_data_reg, e);
	endtask
	task automatic pulse(input logic [3:0] g, input logic [7:0] v);
		@(posedge sys_clk);
		fault_set <= {120'h0, v} << (8 * g);
		@(posedge sys_clk);
		fault_set <= '0;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	initial begin
		rows[0] = {4'h0, 15'h0000, 8'h80, 1'b0, 8'h80};
		rows[1] = {4'h1, 15'h0080, 8'h00, 1'b0, 8'h80};
		rows[2] = {4'h2, 15'h0000, 8'h08, 1'b0, 8'h40};
		rows[3] = {4'h3, 15'h0040, 8'h08, 1'b0, 8'h20};
		rows[4] = {4'h4, 15'h0000, 8'h04, 1'b0, 8'h10};
		rows[5] = {4'h5, 15'h0008, 8'h00, 1'b0, 8'h08};
		rows[6] = {4'h6, 15'h0000, 8'h40, 1'b0, 8'h04};
		rows[7] = {4'h7, 15'h0000, 8'h02, 1'b0, 8'h02};
		rows[8] = {4'h8, 15'h0000, 8'h01, 1'b0, 8'h01};
		rows[9] = {4'h9, 15'h0001, 8'h00, 1'b0, 8'h01};
		rows[10] = {4'ha, 15'h0000, 8'h01, 1'b0, 8'h01};
		rows[11] = {4'hb, 15'h0000, 8'h20, 1'b1, 8'h40};
		rows[12] = {4'hc, 15'h2000, 8'h00, 1'b1, 8'h20};
		rows[13] = {4'hd, 15'h0000, 8'h10, 1'b1, 8'h0c};
		rows[14] = {4'he, 15'h0000, 8'h10, 1'b1, 8'h02};
		rows[15] = {4'hf, 15'h0001, 8'h10, 1'b1, 8'h01};
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		#1 look(8'h00);
		chk({7'h0, irq_reg}, 8'h00);
		rd(`ADDR_ROLLUP, 8'h00);
		rd(`ADDR_CLEAR_A, 8'h00);
		rd(16'h0123, 8'h00);
		$display("reset values done");
		for (int i = 0; i < 16; i++) begin
			@(posedge sys_clk);
			fault_mask <= rows[i][31:17];
			wr(`ADDR_CLEAR_A, 8'hff);
			wr(`ADDR_CLEAR_B, 8'h7f);
			pulse(rows[i][35:32], 8'h05);
			look(rows[i][16:9]);
			rd(`ADDR_FLAGS_BASE + rows[i][35:32], 8'h05);
			wr(rows[i][8] ? `ADDR_CLEAR_B : `ADDR_CLEAR_A, rows[i][7:0]);
			repeat (3) @(posedge sys_clk);
			#1 look(8'h00);
			rd(`ADDR_FLAGS_BASE + rows[i][35:32], 8'h00);
			$display("row %0d done", i);
		end
		@(posedge sys_clk);
		fault_mask <= '0;
		pulse(4'h0, 8'h05);
		wr(`ADDR_CLEAR_A, 8'h7f);
		wr(`ADDR_ROLLUP, 8'h00);
		repeat (3) @(posedge sys_clk);
		#1 look(8'h80);
		rd(`ADDR_ROLLUP, 8'h80);
		$display("write zero test done");
		wr(`ADDR_CLEAR_A, 8'h80);
		wr(`ADDR_IRQ_CLEAR, 8'hff);
		wr(`ADDR_IRQ_ENABLE, 8'h80);
		pulse(4'h1, 8'h01);
		chk({7'h0, irq_reg}, 8'h01);
		rd(`ADDR_IRQ_STATUS, 8'h80);
		wr(`ADDR_IRQ_ENABLE, 8'h00);
		repeat (2) @(posedge sys_clk);
		#1 chk({7'h0, irq_reg}, 8'h00);
		wr(`ADDR_CLEAR_A, 8'h80);
		wr(`ADDR_IRQ_CLEAR, 8'h80);
		wr(`ADDR_IRQ_ENABLE, 8'h80);
		repeat (3) @(posedge sys_clk);
		#1 chk({7'h0, irq_reg}, 8'h00);
		rd(`ADDR_IRQ_STATUS, 8'h00);
		$display("interrupt test done");
		pulse(4'h7, 8'h01);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		#1 look(8'h00);
		chk({7'h0, irq_reg}, 8'h00);
		rd(`ADDR_FLAGS_BASE + 16'h0007, 8'h00);
		$display("second reset test done");
		close_out();
	end
endmodule
